// file: tsd_trim_swap_regs.sv
// AXI4-Lite register bank holding converter trims and the swap overlap delay.
// How it works
// - Eight-bit gain trim at index 0x7A drives all converter cores together.
// - Band-gap trim uses bits 3:0 at index 0x7C; bits 7:4 stored too.
// - After reset each trim takes its fuse value; software may read and overwrite.
// - Four eight-bit termination trims, inputs A to D, at indices 0x7E to 0x81.
// - Five-bit delay field at index 0x9A, resets to 0x08, range 0 to 31.
// - Overlap lasts four plus twice the delay field in converter cycles.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsd_trim_swap_regs (
    input wire logic core_clk, // Register and converter clock, 200 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_gain, // Fuse gain trim.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_bandgap, // Fuse band-gap trim.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_a, // Fuse input A termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_b, // Fuse input B termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_c, // Fuse input C termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_d, // Fuse input D termination.
    input wire logic swap_start, // Pulse from calibration: begin a swap overlap.
    input wire logic [tsd_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [tsd_pkg::DATA_W-1:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [tsd_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [tsd_pkg::DATA_W-1:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic [tsd_pkg::TRIM_W-1:0] core_gain_adjust, // Gain trim to all cores.
    output logic [tsd_pkg::BG_FIELD_W-1:0] bandgap_trim, // Band-gap trim field.
    output logic [tsd_pkg::TRIM_W-1:0] term_trim_a, // Input A termination trim.
    output logic [tsd_pkg::TRIM_W-1:0] term_trim_b, // Input B termination trim.
    output logic [tsd_pkg::TRIM_W-1:0] term_trim_c, // Input C termination trim.
    output logic [tsd_pkg::TRIM_W-1:0] term_trim_d, // Input D termination trim.
    output logic overlap_active, // High while two converters share an input.
    output logic swap_done, // Pulse as an overlap ends.
    output logic trims_loaded // High once fuse values are captured, one cycle before the trims take them.
);
    import tsd_pkg::*;

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [TRIM_W-1:0] regs_r [NREG];
    logic [TRIM_W-1:0] cap_gain;
    logic [TRIM_W-1:0] cap_bandgap;
    logic [TRIM_W-1:0] cap_term_a;
    logic [TRIM_W-1:0] cap_term_b;
    logic [TRIM_W-1:0] cap_term_c;
    logic [TRIM_W-1:0] cap_term_d;
    logic load_pulse;
    logic awready_r;
    logic wready_r;
    logic arready_r;
    logic aw_got_r;
    logic w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [TRIM_W-1:0] wbyte_r;
    logic wlane0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DATA_W-1:0] rdata_r;
    logic [SEL_W-1:0] wr_sel;
    logic [SEL_W-1:0] rd_sel;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic do_write;
    logic ar_take;

    // ------------------------------------------------------------------
    // Fuse capture and overlap timing.
    // ------------------------------------------------------------------
    tsd_fuse_loader u_fuse (
        .core_clk(core_clk),
        .rst(rst),
        .fuse_gain(fuse_gain),
        .fuse_bandgap(fuse_bandgap),
        .fuse_term_a(fuse_term_a),
        .fuse_term_b(fuse_term_b),
        .fuse_term_c(fuse_term_c),
        .fuse_term_d(fuse_term_d),
        .cap_gain(cap_gain),
        .cap_bandgap(cap_bandgap),
        .cap_term_a(cap_term_a),
        .cap_term_b(cap_term_b),
        .cap_term_c(cap_term_c),
        .cap_term_d(cap_term_d),
        .load_pulse(load_pulse),
        .loaded(trims_loaded)
    );

    tsd_overlap_timer u_ovl (
        .core_clk(core_clk),
        .rst(rst),
        .swap_start(swap_start),
        .overlap_delay(regs_r[REG_SWAP][SWAP_FIELD_W-1:0]),
        .overlap_active(overlap_active),
        .swap_done(swap_done)
    );

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    // register index decode
    assign wr_sel = tsd_decode(awaddr_r);
    assign rd_sel = tsd_decode(s_axi_araddr);
    assign wr_idx = wr_sel[2:0];
    assign rd_idx = rd_sel[2:0];
    assign do_write = aw_got_r && w_got_r && !bvalid_r;
    assign ar_take = s_axi_arvalid && arready_r;

    // ------------------------------------------------------------------
    // Write address and data channels, taken in either order.
    // ------------------------------------------------------------------
    // Address channel; ready stays low until the fuse values have landed.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (load_pulse || (bvalid_r && s_axi_bready)) begin
                awready_r <= 1'b1;
            end
            if (do_write) begin
                aw_got_r <= 1'b0;
            end
        end
    end

    // Data channel; only byte lane 0 carries register bits.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wready_r <= 1'b0;
            w_got_r <= 1'b0;
            wbyte_r <= '0;
            wlane0_r <= 1'b0;
        end else begin
            if (s_axi_wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_got_r <= 1'b1;
                wbyte_r <= s_axi_wdata[TRIM_W-1:0];
                wlane0_r <= s_axi_wstrb[0];
            end else if (load_pulse || (bvalid_r && s_axi_bready)) begin
                wready_r <= 1'b1;
            end
            if (do_write) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // Write response; an unmapped address answers with a slave error.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_sel[SEL_W-1] ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register storage.
    // ------------------------------------------------------------------
    // fuse load after reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < NREG; i++) begin
                regs_r[i] <= RST_TRIM;
            end
            regs_r[REG_SWAP] <= RST_SWAP;
        end else if (load_pulse) begin
            regs_r[REG_GAIN] <= cap_gain;
            regs_r[REG_BG] <= cap_bandgap;
            regs_r[REG_TERM_A] <= cap_term_a;
            regs_r[REG_TERM_B] <= cap_term_b;
            regs_r[REG_TERM_C] <= cap_term_c;
            regs_r[REG_TERM_D] <= cap_term_d;
        end else if (do_write && wr_sel[SEL_W-1] && wlane0_r) begin
            regs_r[wr_idx] <= wbyte_r;
        end
    end

    // ------------------------------------------------------------------
    // Read channel.
    // ------------------------------------------------------------------
    // read returns stored value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rd_sel[SEL_W-1] ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_sel[SEL_W-1] ? {{(DATA_W-TRIM_W){1'b0}}, regs_r[rd_idx]} : '0;
        end else if (load_pulse || (rvalid_r && s_axi_rready)) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop.
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign core_gain_adjust = regs_r[REG_GAIN];
    assign bandgap_trim = regs_r[REG_BG][BG_FIELD_W-1:0];
    assign term_trim_a = regs_r[REG_TERM_A];
    assign term_trim_b = regs_r[REG_TERM_B];
    assign term_trim_c = regs_r[REG_TERM_C];
    assign term_trim_d = regs_r[REG_TERM_D];

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [OVL_CNT_W-1:0] ovl_len_r;
    logic [OVL_CNT_W-1:0] ovl_target_r;

    // Measures each overlap window and the length it should have.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovl_len_r <= '0;
            ovl_target_r <= '0;
        end else begin
            ovl_len_r <= overlap_active ? ovl_len_r + OVL_CNT_W'(1) : '0;
            if (swap_start && !overlap_active) begin
                ovl_target_r <= tsd_overlap_cycles(regs_r[REG_SWAP][SWAP_FIELD_W-1:0]);
            end
        end
    end

    a_bresp_holds: assert property (bvalid_r && !s_axi_bready |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before bready");
    a_rdata_holds: assert property (rvalid_r && !s_axi_rready |=> rvalid_r && $stable(rdata_r))
        else $error("read data changed before rready");
    a_write_stores: assert property (do_write && wr_sel[SEL_W-1] && wlane0_r |=>
        regs_r[$past(wr_idx)] == $past(wbyte_r))
        else $error("mapped write did not store its byte");
    a_read_back: assert property (ar_take && rd_sel[SEL_W-1] && !do_write |=>
        rvalid_r && rresp_r == RESP_OKAY && rdata_r[TRIM_W-1:0] == regs_r[$past(rd_idx)])
        else $error("read did not return the stored value");
    a_fuse_loaded: assert property (load_pulse |=> regs_r[REG_GAIN] == $past(cap_gain)
        && regs_r[REG_BG] == $past(cap_bandgap) && regs_r[REG_TERM_D] == $past(cap_term_d))
        else $error("fuse values not loaded");
    a_bus_gated: assert property (!trims_loaded |-> !awready_r && !wready_r && !arready_r)
        else $error("bus accepted before fuse load");
    a_swap_reset: assert property ($past(rst) |-> regs_r[REG_SWAP] == RST_SWAP)
        else $error("delay register not at its reset value");
    a_overlap_len: assert property ($fell(overlap_active) |-> ovl_len_r == ovl_target_r)
        else $error("overlap window has the wrong length");
    a_overlap_start: assert property (swap_start && !overlap_active |=> overlap_active[*4])
        else $error("overlap shorter than its base length");
    a_unmapped_err: assert property (do_write && !wr_sel[SEL_W-1] |=> bresp_r == RESP_SLVERR)
        else $error("unmapped write not flagged");
    a_upper_zero: assert property (rvalid_r |-> rdata_r[DATA_W-1:TRIM_W] == '0)
        else $error("upper read bits not zero");

    c_gain_write: cover property (do_write && wr_sel == {1'b1, 3'(REG_GAIN)});
    c_swap_read: cover property (ar_take && rd_sel == {1'b1, 3'(REG_SWAP)});
    c_overlap_done: cover property (swap_done);
    c_unmapped_read: cover property (ar_take && !rd_sel[SEL_W-1]);

endmodule : tsd_trim_swap_regs
`default_nettype wire

// file: tsd_pkg.sv
// Shared constants, types and decode functions for the trim and swap delay register bank.
`default_nettype none
package tsd_pkg;

    // ------------------------------------------------------------------
    // Widths of the bus and of the stored registers.
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int TRIM_W = 8;
    localparam int BG_FIELD_W = 4;
    localparam int SWAP_FIELD_W = 5;
    localparam int NREG = 7;
    localparam int SEL_W = 4;

    // ------------------------------------------------------------------
    // Slots of the register array.
    // ------------------------------------------------------------------
    localparam int REG_GAIN = 0;
    localparam int REG_BG = 1;
    localparam int REG_TERM_A = 2;
    localparam int REG_TERM_B = 3;
    localparam int REG_TERM_C = 4;
    localparam int REG_TERM_D = 5;
    localparam int REG_SWAP = 6;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index.
    // ------------------------------------------------------------------
    typedef logic [7:0] tsd_idx_t;
    localparam tsd_idx_t IDX_GAIN = 8'h7A;
    localparam tsd_idx_t IDX_BG = 8'h7C;
    localparam tsd_idx_t IDX_TERM_A = 8'h7E;
    localparam tsd_idx_t IDX_TERM_B = 8'h7F;
    localparam tsd_idx_t IDX_TERM_C = 8'h80;
    localparam tsd_idx_t IDX_TERM_D = 8'h81;
    localparam tsd_idx_t IDX_SWAP = 8'h9A;
    localparam tsd_idx_t REG_IDX [NREG] = '{IDX_GAIN, IDX_BG, IDX_TERM_A, IDX_TERM_B,
                                            IDX_TERM_C, IDX_TERM_D, IDX_SWAP};

    // ------------------------------------------------------------------
    // Values after reset, overlap timing and bus response codes.
    // ------------------------------------------------------------------
    localparam logic [TRIM_W-1:0] RST_TRIM = 8'h00;
    localparam logic [TRIM_W-1:0] RST_SWAP = 8'h08;
    localparam int OVL_CNT_W = 7;
    localparam logic [OVL_CNT_W-1:0] OVL_BASE_CYC = 7'h04;
    localparam int OVL_SCALE = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Overlap timer states.
    typedef enum logic [0:0] {
        OVL_IDLE = 1'b0,
        OVL_ACTIVE = 1'b1
    } tsd_ovl_e;

    // Returns {hit, slot} for a byte address; misses give all zero.
    function automatic logic [SEL_W-1:0] tsd_decode(input logic [ADDR_W-1:0] addr);
        logic [SEL_W-1:0] sel;
        sel = '0;
        for (int i = 0; i < NREG; i++) begin
            if (addr[ADDR_W-1:2] == {2'h0, REG_IDX[i]}) begin
                sel = {1'b1, 3'(i)};
            end
        end
        return sel;
    endfunction : tsd_decode

    // Number of converter clock cycles that both converters share an input.
    function automatic logic [OVL_CNT_W-1:0] tsd_overlap_cycles(input logic [SWAP_FIELD_W-1:0] dly);
        return OVL_BASE_CYC + OVL_CNT_W'(OVL_SCALE * dly);
    endfunction : tsd_overlap_cycles

endpackage : tsd_pkg
`default_nettype wire

// file: tsd_fuse_loader.sv
// Captures the factory fuse trims once after reset and signals when to load them.
`timescale 1ns/1ps
`default_nettype none
module tsd_fuse_loader (
    input wire logic core_clk, // Register clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_gain, // Fuse value for the core gain trim.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_bandgap, // Fuse value for the band-gap trim.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_a, // Fuse value for input A termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_b, // Fuse value for input B termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_c, // Fuse value for input C termination.
    input wire logic [tsd_pkg::TRIM_W-1:0] fuse_term_d, // Fuse value for input D termination.
    output logic [tsd_pkg::TRIM_W-1:0] cap_gain, // Captured gain trim.
    output logic [tsd_pkg::TRIM_W-1:0] cap_bandgap, // Captured band-gap trim.
    output logic [tsd_pkg::TRIM_W-1:0] cap_term_a, // Captured input A termination.
    output logic [tsd_pkg::TRIM_W-1:0] cap_term_b, // Captured input B termination.
    output logic [tsd_pkg::TRIM_W-1:0] cap_term_c, // Captured input C termination.
    output logic [tsd_pkg::TRIM_W-1:0] cap_term_d, // Captured input D termination.
    output logic load_pulse, // One-cycle pulse: copy captures into the registers.
    output logic loaded // High once the captures are valid.
);
    import tsd_pkg::*;

    // Sequencing: one pulse at the first edge after reset release.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            load_pulse <= 1'b0;
            loaded <= 1'b0;
        end else begin
            load_pulse <= !loaded;
            loaded <= 1'b1;
        end
    end

    // The fuse levels are caught by a clock after release, never by the reset itself.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cap_gain <= RST_TRIM;
            cap_bandgap <= RST_TRIM;
            cap_term_a <= RST_TRIM;
            cap_term_b <= RST_TRIM;
            cap_term_c <= RST_TRIM;
            cap_term_d <= RST_TRIM;
        end else if (!loaded) begin
            cap_gain <= fuse_gain;
            cap_bandgap <= fuse_bandgap;
            cap_term_a <= fuse_term_a;
            cap_term_b <= fuse_term_b;
            cap_term_c <= fuse_term_c;
            cap_term_d <= fuse_term_d;
        end
    end

endmodule : tsd_fuse_loader
`default_nettype wire

// file: tsd_overlap_timer.sv
// Times the window in which two converters sample the same input during a swap.
`timescale 1ns/1ps
`default_nettype none
module tsd_overlap_timer (
    input wire logic core_clk, // Converter clock, shared with the registers.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic swap_start, // One-cycle request to begin an overlap.
    input wire logic [tsd_pkg::SWAP_FIELD_W-1:0] overlap_delay, // Delay field value.
    output logic overlap_active, // High while both converters share the input.
    output logic swap_done // One-cycle pulse as the overlap ends.
);
    import tsd_pkg::*;

    tsd_ovl_e state_r;
    logic [OVL_CNT_W-1:0] cnt_r;

    // The delay is sampled at the start so a late register write cannot stretch a swap.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= OVL_IDLE;
            cnt_r <= '0;
            overlap_active <= 1'b0;
            swap_done <= 1'b0;
        end else begin
            swap_done <= 1'b0;
            unique case (state_r)
                OVL_IDLE: begin
                    if (swap_start) begin
                        state_r <= OVL_ACTIVE;
                        overlap_active <= 1'b1;
                        cnt_r <= tsd_overlap_cycles(overlap_delay) - OVL_CNT_W'(1);
                    end
                end
                OVL_ACTIVE: begin
                    if (cnt_r == '0) begin
                        state_r <= OVL_IDLE;
                        overlap_active <= 1'b0;
                        swap_done <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - OVL_CNT_W'(1);
                    end
                end
            endcase
        end
    end

endmodule : tsd_overlap_timer
`default_nettype wire

// file: trim_and_swap_delay_regs_tb.sv
// Self-checking testbench for the trim and swap delay register bank.
`timescale 1ns/1ps
`default_nettype none
module trim_and_swap_delay_regs_tb;
    import tsd_pkg::*;
    // ------------------------------------------------------------------
    // Signals and design instance.
    // ------------------------------------------------------------------
    logic core_clk, rst, swap_start, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, overlap_active, swap_done, trims_loaded;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, bandgap_trim;
    logic [1:0] bresp, rresp;
    logic [7:0] fuse [6];
    logic [7:0] outs [6];
    logic [7:0] vals [7];
    int n_mismatch = 0;
    int comparisons = 0;

    tsd_trim_swap_regs u_tsd_trim_swap_regs (
        .core_clk(core_clk), .rst(rst), .fuse_gain(fuse[0]), .fuse_bandgap(fuse[1]),
        .fuse_term_a(fuse[2]), .fuse_term_b(fuse[3]), .fuse_term_c(fuse[4]), .fuse_term_d(fuse[5]),
        .swap_start(swap_start), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_gain_adjust(outs[0]), .bandgap_trim(bandgap_trim),
        .term_trim_a(outs[2]), .term_trim_b(outs[3]), .term_trim_c(outs[4]), .term_trim_d(outs[5]),
        .overlap_active(overlap_active), .swap_done(swap_done), .trims_loaded(trims_loaded)
    );
    // Band-gap output widened so every trim compares as a byte.
    assign outs[1] = {4'h0, bandgap_trim};

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [11:0] addr(input int i);
        return {2'h0, REG_IDX[i], 2'h0};
    endfunction : addr

    // Write one byte with ones above it; waits on each handshake.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'hFFFFFF, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk(32'(bresp), 32'(er));
                return;
            end
        end
        chk(32'h0, 32'h1);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk(rdata, exp);
                chk(32'(rresp), 32'(er));
                return;
            end
        end
        chk(32'h0, 32'h1);
    endtask : rd

    // Counts the cycles of one overlap window for a given delay field.
    task automatic ovl(input logic [4:0] d);
        int n;
        wr(addr(REG_SWAP), {3'h0, d}, RESP_OKAY);
        @(posedge core_clk);
        swap_start <= 1'b1;
        @(posedge core_clk);
        swap_start <= 1'b0;
        for (n = 0; n < 80; n++) begin
            @(posedge core_clk);
            if (overlap_active !== 1'b1) break;
        end
        chk(32'(n), 32'd4 + 32'd2 * 32'(d));
        chk(32'(swap_done), 32'h1);
    endtask : ovl

    task automatic close_out;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence.
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Cuts a hang short well past the expected few hundred cycles.
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        {rst, swap_start, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
        fuse = '{8'h11, 8'h0A, 8'h33, 8'h44, 8'h55, 8'h66};
        vals = '{8'hFF, 8'h05, 8'h00, 8'hA5, 8'h80, 8'h7E, 8'h1F};
        repeat (12) @(posedge core_clk);
        chk(32'({trims_loaded, outs[0]}), 32'h0);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'(trims_loaded), 32'h1);
        for (int i = 0; i < 6; i++) begin
            chk(32'(outs[i]), 32'(fuse[i]));
            rd(addr(i), 32'(fuse[i]), RESP_OKAY);
        end
        rd(addr(REG_SWAP), 32'(RST_SWAP), RESP_OKAY);
        for (int i = 0; i < 7; i++) wr(addr(i), vals[i], RESP_OKAY);
        for (int i = 0; i < 7; i++) begin
            rd(addr(i), 32'(vals[i]), RESP_OKAY);
            if (i < 6) chk(32'(outs[i]), 32'(vals[i]));
        end
        wstrb <= 4'hE;
        wr(addr(REG_GAIN), 8'h3C, RESP_OKAY);
        wstrb <= 4'hF;
        rd(addr(REG_GAIN), 32'(vals[0]), RESP_OKAY);
        wr(12'h1EC, 8'h12, RESP_SLVERR);
        rd(12'h1EC, 32'h0, RESP_SLVERR);
        ovl(5'd0);
        ovl(5'd31);
        ovl(5'd7);
        close_out();
    end
endmodule : trim_and_swap_delay_regs_tb
`default_nettype wire
